// ### design/dskc_pkg.sv
package dskc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 25;  // System clock period
  localparam int unsigned TICK_NS = 1000;  // Divider tick, one microsecond
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACK_WAIT_US = 100;  // Longest wait for the drive to take a word
  localparam int unsigned ACK_WAIT_TICKS = ACK_WAIT_US * TICK_NS / TICK_NS;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;  // W: start, word kind, drive
  localparam logic [7:0] OFS_CART = 8'h04;  // RW: cartridge seek fields
  localparam logic [7:0] OFS_MH_CYL = 8'h08;  // RW: multi-head target cylinder
  localparam logic [7:0] OFS_MH_HEAD = 8'h0C;  // RW: multi-head head index
  localparam logic [7:0] OFS_STATUS = 8'h10;  // R: busy and sticky flags, W1C
  localparam logic [7:0] OFS_LAST = 8'h14;  // R: last word sent

  // ****************************************
  // Register field positions
  // ****************************************
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_KIND_LSB = 1;
  localparam int unsigned CTRL_DRIVE_LSB = 3;
  localparam int unsigned CART_DIR_FIELD = 0;
  localparam int unsigned CART_UPPER_FIELD = 1;
  localparam int unsigned CART_DIFF_FIELD = 2;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  localparam int unsigned ST_BAD_BIT = 2;
  localparam int unsigned ST_TIMEOUT_BIT = 3;

  // ****************************************
  // Drive command word layout
  // ****************************************
  localparam int unsigned CART_MARKER_BIT = 0;
  localparam int unsigned STATUS_REQUEST_FLAG_BIT = 1;
  localparam int unsigned CART_DIR_BIT = 2;
  localparam int unsigned CART_RESET_BIT = 3;
  localparam int unsigned CART_HEAD_BIT = 4;
  localparam int unsigned CYL_DIFFERENCE_LSB = 7;
  localparam int unsigned CYL_DIFFERENCE_MSB = 15;
  localparam int unsigned CYL_ADDRESS_LSB = 0;
  localparam int unsigned CYL_ADDRESS_MSB = 9;
  localparam int unsigned CYL_WORD_FLAG_BIT = 13;
  localparam int unsigned HEAD_CHOICE_FLAG_BIT = 14;
  localparam int unsigned CONTROL_SELECT_BIT = 15;
  localparam int unsigned HEAD_INDEX_LSB = 0;
  localparam int unsigned HEAD_INDEX_MSB = 3;
  localparam logic [3:0] HEAD_COUNT = 4'hE;  // Fourteen heads, index 0..13

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [10:0] CART_RST = 11'h000;
  localparam logic [9:0] MH_CYL_RST = 10'h000;
  localparam logic [3:0] MH_HEAD_RST = 4'h0;
  localparam logic [31:0] WORD_RST = 32'h00000000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    KIND_CART_SEEK,
    KIND_MH_SEEK,
    KIND_MH_HEAD,
    KIND_SPARE
  } dskc_kind_type;

  // Everything software has asked for in one order
  typedef struct packed {
    logic [1:0] kind;
    logic cart_dir;
    logic cart_upper;
    logic [8:0] cart_diff;
    logic [9:0] mh_cyl;
    logic [3:0] mh_head;
  } dskc_order_type;

  // What leaves toward the drives
  typedef struct packed {
    logic [31:0] word;
    logic [1:0] drive;
  } dskc_cmd_type;

endpackage

// ### design/dskc_tick_divider.sv
`timescale 1ns/1ps
// ****************************************
// One-cycle enable every DIVIDE clocks
// ****************************************
module dskc_tick_divider
  import dskc_pkg::*;
#(
  parameter int unsigned DIVIDE = TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic tick
);

  // A count of one would make the enable a constant
  initial begin
    if (DIVIDE < 2 || DIVIDE > 65535) begin
      $error("dskc_tick_divider: DIVIDE out of range");
    end
  end

  logic [15:0] count_ff;  // Cycles since last tick
  logic [15:0] nxt_count;
  logic tick_ff;  // Registered enable
  logic nxt_tick;

  // Next count and enable
  always_comb begin
    if (count_ff == 16'(DIVIDE - 1)) begin
      nxt_count = 16'h0000;
      nxt_tick = 1'b1;
    end else begin
      nxt_count = count_ff + 16'h0001;
      nxt_tick = 1'b0;
    end
  end

  // Register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

// ### design/dskc_word_builder.sv
`timescale 1ns/1ps
// ****************************************
// Builds a drive command word from an order
// ****************************************
module dskc_word_builder
  import dskc_pkg::*;
(
  input dskc_order_type order,
  output logic [31:0] word,
  output logic bad
);

  // Unused positions are driven zero so the drive sees a clean word
  function automatic logic [31:0] cart_seek_word(input dskc_order_type o);
    logic [31:0] w;
    w = WORD_RST;
    w[CART_MARKER_BIT] = 1'b1;
    w[STATUS_REQUEST_FLAG_BIT] = 1'b0;
    w[CART_DIR_BIT] = o.cart_dir;
    w[CART_RESET_BIT] = 1'b0;
    w[CART_HEAD_BIT] = o.cart_upper;
    w[CYL_DIFFERENCE_MSB:CYL_DIFFERENCE_LSB] = o.cart_diff;
    return w;
  endfunction

  function automatic logic [31:0] mh_seek_word(input dskc_order_type o);
    logic [31:0] w;
    w = WORD_RST;
    w[CYL_ADDRESS_MSB:CYL_ADDRESS_LSB] = o.mh_cyl;
    w[CYL_WORD_FLAG_BIT] = 1'b1;
    w[HEAD_CHOICE_FLAG_BIT] = 1'b0;
    w[CONTROL_SELECT_BIT] = 1'b0;
    return w;
  endfunction

  function automatic logic [31:0] mh_head_word(input dskc_order_type o);
    logic [31:0] w;
    w = WORD_RST;
    w[HEAD_INDEX_MSB:HEAD_INDEX_LSB] = o.mh_head;
    w[HEAD_CHOICE_FLAG_BIT] = 1'b1;
    return w;
  endfunction

  // Pick the layout; a head beyond the last or an unknown kind is refused
  always_comb begin
    word = WORD_RST;
    bad = 1'b0;
    case (dskc_kind_type'(order.kind))
      KIND_CART_SEEK: begin
        word = cart_seek_word(order);
      end
      KIND_MH_SEEK: begin
        word = mh_seek_word(order);
      end
      KIND_MH_HEAD: begin
        word = mh_head_word(order);
        bad = (order.mh_head >= HEAD_COUNT);
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

endmodule

// ### design/dskc_seek_issuer.sv
`timescale 1ns/1ps
// ****************************************
// Seek and head-select word issuer
// ****************************************
module dskc_seek_issuer
  import dskc_pkg::*;
#(
  parameter int unsigned ACK_TICKS = ACK_WAIT_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [31:0] cmd_word,
  output logic [1:0] cmd_drive,
  output logic cmd_valid,
  input wire logic cmd_ack
);

  // The wait counter is 16 bits wide
  initial begin
    if (ACK_TICKS < 1 || ACK_TICKS > 65535) begin
      $error("dskc_seek_issuer: ACK_TICKS out of range");
    end
  end

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic ack_meta_ff;  // First stage, read only by the second
  logic ack_sync_ff;  // Safe copy of the drive's acknowledge

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_meta_ff <= 1'b0;
      ack_sync_ff <= 1'b0;
    end else begin
      ack_meta_ff <= cmd_ack;
      ack_sync_ff <= ack_meta_ff;
    end
  end

  // ****************************************
  // Microsecond tick and word builder
  // ****************************************
  logic tick;  // One-cycle enable, once per microsecond
  logic [31:0] built_word;  // Word for the current order
  logic built_bad;  // Order cannot be served

  dskc_tick_divider #(
    .DIVIDE(TICK_CYCLES)
  ) u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick)
  );

  dskc_order_type order;  // Live view of the order registers
  logic [10:0] cart_ff;  // Direction, upper head, difference
  logic [9:0] mh_cyl_ff;  // Target cylinder
  logic [3:0] mh_head_ff;  // Head index
  logic [1:0] kind_ff;  // Word kind taken from the last control write

  assign order = '{kind: kind_ff, cart_dir: cart_ff[CART_DIR_FIELD],
                   cart_upper: cart_ff[CART_UPPER_FIELD],
                   cart_diff: cart_ff[CART_DIFF_FIELD +: 9],
                   mh_cyl: mh_cyl_ff, mh_head: mh_head_ff};

  dskc_word_builder u_build (
    .order(order),
    .word(built_word),
    .bad(built_bad)
  );

  // ****************************************
  // Software registers
  // ****************************************
  logic [10:0] nxt_cart;
  logic [9:0] nxt_mh_cyl;
  logic [3:0] nxt_mh_head;
  logic [1:0] nxt_kind;
  logic [1:0] drive_ff;  // Drive chosen at the last control write
  logic [1:0] nxt_drive;
  logic start_ff;  // One-cycle request from a control write
  logic nxt_start;

  // Kind and drive land in the same cycle as the start is seen
  always_comb begin
    nxt_cart = cart_ff;
    nxt_mh_cyl = mh_cyl_ff;
    nxt_mh_head = mh_head_ff;
    nxt_kind = kind_ff;
    nxt_drive = drive_ff;
    nxt_start = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          nxt_kind = reg_wdata[CTRL_KIND_LSB +: 2];
          nxt_drive = reg_wdata[CTRL_DRIVE_LSB +: 2];
          nxt_start = reg_wdata[CTRL_START_BIT];
        end
        OFS_CART: begin
          nxt_cart = reg_wdata[10:0];
        end
        OFS_MH_CYL: begin
          nxt_mh_cyl = reg_wdata[9:0];
        end
        OFS_MH_HEAD: begin
          nxt_mh_head = reg_wdata[3:0];
        end
        default: begin
          nxt_start = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cart_ff <= CART_RST;
      mh_cyl_ff <= MH_CYL_RST;
      mh_head_ff <= MH_HEAD_RST;
      kind_ff <= 2'h0;
      drive_ff <= 2'h0;
      start_ff <= 1'b0;
    end else begin
      cart_ff <= nxt_cart;
      mh_cyl_ff <= nxt_mh_cyl;
      mh_head_ff <= nxt_mh_head;
      kind_ff <= nxt_kind;
      drive_ff <= nxt_drive;
      start_ff <= nxt_start;
    end
  end

  // ****************************************
  // Issue state machine
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD,
    ST_RELEASE
  } dskc_state_type;

  dskc_state_type state_ff;
  dskc_state_type nxt_state;
  logic [31:0] word_ff;  // Word on the drive bus
  logic [31:0] nxt_word;
  logic [1:0] cmd_drive_ff;  // Drive the word is meant for
  logic [1:0] nxt_cmd_drive;
  logic valid_ff;  // Word is being offered
  logic nxt_valid;
  logic [1:0] sent_kind_ff;  // Kind of the word on the bus
  logic [1:0] nxt_sent_kind;
  logic [15:0] wait_ff;  // Microseconds spent waiting for the drive
  logic [15:0] nxt_wait;
  logic done_ff, bad_ff, tmo_ff;  // Sticky status flags
  logic nxt_done, nxt_bad, nxt_tmo;
  logic clr_wr;  // Write to the status register
  logic ev_done, ev_bad, ev_tmo;  // Events this cycle

  // Word stands still while offered: the drive samples it at leisure
  always_comb begin
    nxt_state = state_ff;
    nxt_word = word_ff;
    nxt_cmd_drive = cmd_drive_ff;
    nxt_valid = valid_ff;
    nxt_sent_kind = sent_kind_ff;
    nxt_wait = wait_ff;
    ev_done = 1'b0;
    ev_bad = 1'b0;
    ev_tmo = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (start_ff && built_bad) begin
          ev_bad = 1'b1;
        end else if (start_ff) begin
          nxt_word = built_word;
          nxt_cmd_drive = drive_ff;
          nxt_sent_kind = kind_ff;
          nxt_valid = 1'b1;
          nxt_wait = 16'h0000;
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (ack_sync_ff) begin
          nxt_valid = 1'b0;
          ev_done = 1'b1;
          nxt_state = ST_RELEASE;
        end else if (wait_ff == 16'(ACK_TICKS)) begin
          // A dead drive must not hang the controller
          nxt_valid = 1'b0;
          ev_tmo = 1'b1;
          nxt_state = ST_IDLE;
        end else if (tick) begin
          nxt_wait = wait_ff + 16'h0001;
        end
      end
      ST_RELEASE: begin
        if (!ack_sync_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_valid = 1'b0;
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Sticky flags: a new event beats a clear in the same cycle
  always_comb begin
    clr_wr = reg_wr && (reg_addr == OFS_STATUS);
    nxt_done = ev_done | (done_ff & ~(clr_wr & reg_wdata[ST_DONE_BIT]));
    nxt_bad = ev_bad | (bad_ff & ~(clr_wr & reg_wdata[ST_BAD_BIT]));
    nxt_tmo = ev_tmo | (tmo_ff & ~(clr_wr & reg_wdata[ST_TIMEOUT_BIT]));
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      word_ff <= WORD_RST;
      cmd_drive_ff <= 2'h0;
      valid_ff <= 1'b0;
      sent_kind_ff <= 2'h0;
      wait_ff <= 16'h0000;
      done_ff <= 1'b0;
      bad_ff <= 1'b0;
      tmo_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      word_ff <= nxt_word;
      cmd_drive_ff <= nxt_cmd_drive;
      valid_ff <= nxt_valid;
      sent_kind_ff <= nxt_sent_kind;
      wait_ff <= nxt_wait;
      done_ff <= nxt_done;
      bad_ff <= nxt_bad;
      tmo_ff <= nxt_tmo;
    end
  end

  // ****************************************
  // Read port, data one cycle after the strobe
  // ****************************************
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CART: nxt_rdata = {21'h000000, cart_ff};
        OFS_MH_CYL: nxt_rdata = {22'h000000, mh_cyl_ff};
        OFS_MH_HEAD: nxt_rdata = {28'h0000000, mh_head_ff};
        OFS_STATUS: nxt_rdata = {28'h0000000, tmo_ff, bad_ff, done_ff, state_ff != ST_IDLE};
        OFS_LAST: nxt_rdata = word_ff;
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign cmd_word = word_ff;
  assign cmd_drive = cmd_drive_ff;
  assign cmd_valid = valid_ff;

  // ****************************************
  // Checks on the words offered
  // ****************************************
  chk_cart_marker_set: assert property (@(posedge sys_clk) disable iff (rst)
    valid_ff && sent_kind_ff == KIND_CART_SEEK |-> word_ff[CART_MARKER_BIT])
    else $error("cartridge seek without marker");
  chk_cart_status_clear: assert property (@(posedge sys_clk) disable iff (rst)
    valid_ff && sent_kind_ff == KIND_CART_SEEK |-> !word_ff[STATUS_REQUEST_FLAG_BIT])
    else $error("cartridge seek with status request set");
  chk_cart_direction: assert property (@(posedge sys_clk) disable iff (rst)
    start_ff && state_ff == ST_IDLE && kind_ff == KIND_CART_SEEK
    |=> word_ff[CART_DIR_BIT] == $past(cart_ff[CART_DIR_FIELD]) && valid_ff)
    else $error("direction bit wrong");
  chk_cart_reset_clear: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(valid_ff) && sent_kind_ff == KIND_CART_SEEK |-> !word_ff[CART_RESET_BIT])
    else $error("cartridge seek with reset bit set");
  chk_cart_head_diff: assert property (@(posedge sys_clk) disable iff (rst)
    start_ff && state_ff == ST_IDLE && kind_ff == KIND_CART_SEEK
    |=> word_ff[CART_HEAD_BIT] == $past(cart_ff[CART_UPPER_FIELD])
        && word_ff[CYL_DIFFERENCE_MSB:CYL_DIFFERENCE_LSB] == $past(cart_ff[10:2]))
    else $error("head or difference field wrong");
  chk_mh_cylinder: assert property (@(posedge sys_clk) disable iff (rst)
    start_ff && state_ff == ST_IDLE && kind_ff == KIND_MH_SEEK
    |=> word_ff[CYL_ADDRESS_MSB:CYL_ADDRESS_LSB] == $past(mh_cyl_ff) && word_ff[31:16] == 16'h0000)
    else $error("cylinder address wrong");
  chk_mh_word_flags: assert property (@(posedge sys_clk) disable iff (rst)
    valid_ff && sent_kind_ff == KIND_MH_SEEK
    |-> word_ff[CYL_WORD_FLAG_BIT] && !word_ff[HEAD_CHOICE_FLAG_BIT] && !word_ff[CONTROL_SELECT_BIT])
    else $error("multi-head seek flags wrong");
  chk_head_one_of: assert property (@(posedge sys_clk) disable iff (rst)
    valid_ff && sent_kind_ff == KIND_MH_HEAD
    |-> word_ff[HEAD_INDEX_MSB:HEAD_INDEX_LSB] < HEAD_COUNT && word_ff[HEAD_CHOICE_FLAG_BIT]
        && !word_ff[CYL_WORD_FLAG_BIT] && !word_ff[CONTROL_SELECT_BIT])
    else $error("head select word wrong");
  chk_bad_refused: assert property (@(posedge sys_clk) disable iff (rst)
    start_ff && state_ff == ST_IDLE && built_bad |=> !valid_ff ##0 bad_ff)
    else $error("bad order was issued");

endmodule

// ### dv/dskc_drive_model.sv
`timescale 1ns/1ps
// ****************************************
// Drive model: takes one word, answers on cmd_ack
// ****************************************
module dskc_drive_model
  import dskc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] cmd_word,
  input wire logic [1:0] cmd_drive,
  input wire logic cmd_valid,
  input wire logic [7:0] ack_delay,
  input wire logic ack_off,
  output logic cmd_ack,
  output logic [31:0] got_word,
  output logic [1:0] got_drive,
  output logic [7:0] got_count
);
  logic [7:0] wait_cnt;  // Cycles since the word was offered
  logic taken;  // Word of this offer already logged
  logic seek_dir;  // Travel toward lower cylinders
  logic seek_upper;  // Upper head chosen
  logic [8:0] seek_diff;  // Relative cylinder count
  logic [9:0] abs_cyl;  // Absolute target cylinder
  logic [3:0] head_idx;  // Head enabled by a head-select word
  logic head_ok;  // Index names one of the fourteen heads

  // Field decode looks only at meaningful bits, loose bits never reach it
  always_comb begin
    seek_dir = got_word[CART_DIR_BIT];
    seek_upper = got_word[CART_HEAD_BIT];
    seek_diff = got_word[CYL_DIFFERENCE_MSB:CYL_DIFFERENCE_LSB];
    abs_cyl = got_word[CYL_ADDRESS_MSB:CYL_ADDRESS_LSB];
    head_idx = got_word[HEAD_INDEX_MSB:HEAD_INDEX_LSB];
    head_ok = head_idx < HEAD_COUNT;
  end

  // Ack rises after a chosen delay and falls only once the offer is gone
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 8'h00;
      cmd_ack <= 1'b0;
      got_word <= 32'h00000000;
      got_drive <= 2'h0;
      got_count <= 8'h00;
      taken <= 1'b0;
    end else if (!cmd_valid) begin
      cmd_ack <= 1'b0;
      wait_cnt <= 8'h00;
      taken <= 1'b0;
    end else begin
      if (!taken) begin
        // Log the word exactly as it stood on the bus
        got_word <= cmd_word;
        got_drive <= cmd_drive;
        got_count <= got_count + 8'h01;
        taken <= 1'b1;
      end
      // A silent drive never answers, so the controller must time out
      if (!ack_off && wait_cnt >= ack_delay) begin
        cmd_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end
endmodule

// ### dv/test_dskc_seek_issuer.sv
`timescale 1ns/1ps
// ****************************************
// Register-level test of the seek issuer
// ****************************************
module test_dskc_seek_issuer;
  import dskc_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] val;
    logic [31:0] rb;
    logic [31:0] ctrl;
    logic [31:0] word;
    logic [31:0] st;
  } dskc_tcase_type;
  logic sys_clk, rst, reg_wr, reg_rd, cmd_valid, cmd_ack, ack_off;
  logic [7:0] reg_addr, ack_delay, got_count, exp_count;
  logic [31:0] reg_wdata, reg_rdata, cmd_word, got_word, v;
  logic [1:0] cmd_drive, got_drive;
  int n_mismatch, checks_done, cyc;
  // Every readable register plus one unmapped address, all zero after reset
  logic [7:0] rst_addr [6] = '{OFS_CART, OFS_MH_CYL, OFS_MH_HEAD, OFS_STATUS, OFS_LAST, 8'h20};
  // Cartridge, multi-head seek, head select, then two refusals
  dskc_tcase_type tc [8] = '{
    '{OFS_CART, 32'h000007FF, 32'h000007FF, 32'h00000011, 32'h0000FF95, 32'h00000002},
    '{OFS_CART, 32'hFFFFF804, 32'h00000004, 32'h00000001, 32'h00000081, 32'h00000002},
    '{OFS_MH_CYL, 32'hFFFFFFFF, 32'h000003FF, 32'h00000003, 32'h000023FF, 32'h00000002},
    '{OFS_MH_CYL, 32'h00000000, 32'h00000000, 32'h0000000B, 32'h00002000, 32'h00000002},
    '{OFS_MH_HEAD, 32'h0000000D, 32'h0000000D, 32'h0000001D, 32'h0000400D, 32'h00000002},
    '{OFS_MH_HEAD, 32'h00000000, 32'h00000000, 32'h00000005, 32'h00004000, 32'h00000002},
    '{OFS_MH_HEAD, 32'h0000000E, 32'h0000000E, 32'h00000005, 32'h00004000, 32'h00000004},
    '{OFS_CART, 32'h00000000, 32'h00000000, 32'h00000007, 32'h00004000, 32'h00000004}};

  dskc_seek_issuer #(.ACK_TICKS(2)) i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_word(cmd_word), .cmd_drive(cmd_drive), .cmd_valid(cmd_valid), .cmd_ack(cmd_ack));
  dskc_drive_model i_drive (.sys_clk(sys_clk), .rst(rst), .cmd_word(cmd_word),
    .cmd_drive(cmd_drive), .cmd_valid(cmd_valid), .ack_delay(ack_delay), .ack_off(ack_off),
    .cmd_ack(cmd_ack), .got_word(got_word), .got_drive(got_drive), .got_count(got_count));

  // ****************************************
  // Clock, watchdog and shared tasks
  // ****************************************
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  // Guards against a hang in any wait loop
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  // One-cycle write strobe beside address and data
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Poll status until busy falls, bounded
  task automatic wait_idle(output logic [31:0] s);
    // Busy shows one cycle after the start write returns, so even a quick poll would already see it set
    repeat (2) @(posedge sys_clk);
    for (int k = 0; k < 300; k++) begin
      reg_read(OFS_STATUS, s);
      if (s[ST_BUSY_BIT] === 1'b0) break;
    end
  endtask

  task automatic complete_run();
    $display("counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, ack_off} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    ack_delay = 8'h00;
    exp_count = 8'h00;
    n_mismatch = 0;
    checks_done = 0;
    cyc = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, unmapped address reads zero
    foreach (rst_addr[i]) begin
      reg_read(rst_addr[i], v);
      chk("reset read", 32'h00000000, v);
    end
    chk("cmd_valid", 32'h00000000, {31'h0, cmd_valid});
    $display("test reset done");
    // Each word kind with prompt and slow drives, loose bits, refusals
    for (int i = 0; i < 8; i++) begin
      ack_delay <= 8'(i * 3);
      reg_write(tc[i].addr, tc[i].val);
      reg_read(tc[i].addr, v);
      chk("field readback", tc[i].rb, v);
      reg_write(OFS_CTRL, tc[i].ctrl);
      wait_idle(v);
      chk("status", tc[i].st, v);
      if (tc[i].st[ST_DONE_BIT]) exp_count = exp_count + 8'h01;
      chk("word at drive", tc[i].word, got_word);
      chk("words taken", {24'h0, exp_count}, {24'h0, got_count});
      reg_read(OFS_LAST, v);
      chk("last word", tc[i].word, v);
      if (tc[i].st[ST_DONE_BIT]) chk("drive", {30'h0, tc[i].ctrl[4:3]}, {30'h0, got_drive});
      reg_write(OFS_STATUS, 32'h0000000E);
      reg_read(OFS_STATUS, v);
      chk("status cleared", 32'h00000000, v);
      $display("test case %0d done", i);
    end
    // Silent drive: offer withdrawn and timeout flagged
    ack_off <= 1'b1;
    reg_write(OFS_CTRL, 32'h00000003);
    wait_idle(v);
    chk("timeout flag", 32'h00000008, v & 32'h00000008);
    chk("cmd_valid", 32'h00000000, {31'h0, cmd_valid});
    ack_off <= 1'b0;
    reg_write(OFS_STATUS, 32'h0000000E);
    exp_count = exp_count + 8'h01;
    $display("test timeout done");
    // Second start while busy is ignored
    // Slow enough to be busy at the second start, well inside the timeout
    ack_delay <= 8'd20;
    reg_write(OFS_CTRL, 32'h00000001);
    reg_write(OFS_CTRL, 32'h00000003);
    wait_idle(v);
    chk("busy start status", 32'h00000002, v);
    chk("busy start word", 32'h00000001, got_word);
    chk("busy start count", {24'h0, exp_count + 8'h01}, {24'h0, got_count});
    $display("test busy start done");
    complete_run();
  end
endmodule
